// *** hdl/config_word_pkg.sv ***
package config_word_pkg;
  // Program-space addresses
  localparam logic [13:0] CFG_WORD_ADDR   = 14'h2007;
  localparam logic [13:0] ID_BASE_ADDR    = 14'h2000;
  localparam logic [13:0] HALF_BOUNDARY   = 14'h0800;
  // APB register byte offsets
  localparam logic [7:0]  OFS_FUSE_WORD   = 8'h00;
  localparam logic [7:0]  OFS_ACCESS_CHK  = 8'h04;
  localparam logic [7:0]  OFS_ID_BASE     = 8'h10;
  // Field positions of the configuration word
  localparam int          POS_DEBUG_DIS   = 13;
  localparam int          POS_GUARD_HI    = 11;
  localparam int          POS_GUARD_LO    = 10;
  localparam int          POS_BROWNOUT    = 8;
  localparam int          POS_READ_GUARD  = 6;
  localparam int          POS_RESET_PIN   = 5;
  localparam int          POS_PWRUP_DIS   = 4;
  localparam int          POS_WATCHDOG    = 3;
  // Unimplemented bits 12, 9, 7, 2..0 forced to one
  localparam logic [13:0] UNIMPL_MASK     = 14'h1287;
  // Erased fuse value after reset
  localparam logic [13:0] FUSE_RESET      = 14'h3FFF;
  localparam logic [13:0] ID_RESET        = 14'h3FFF;
  // Self-write guard codes
  localparam logic [1:0]  GUARD_ALL       = 2'h0;
  localparam logic [1:0]  GUARD_LOWER     = 2'h1;
  localparam logic [1:0]  GUARD_NONE      = 2'h3;
  localparam int          ID_COUNT        = 4;
endpackage : config_word_pkg

// *** hdl/write_guard.sv ***
`timescale 1ns/1ps
module write_guard
  import config_word_pkg::*;
(
  input  wire logic [1:0]  guardField,
  input  wire logic [13:0] writeAddr,
  output logic             writeAllowed
);
  // Self-write permission depends on the guard field and, for GUARD_LOWER, the write address
  always_comb begin
    case (guardField)
      GUARD_ALL:   writeAllowed = 1'b0;
      GUARD_LOWER: writeAllowed = (writeAddr >= HALF_BOUNDARY);
      GUARD_NONE:  writeAllowed = 1'b1;
      default:     writeAllowed = 1'b0;
    endcase
  end
endmodule : write_guard

// *** hdl/config_word_code_protection.sv ***
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module config_word_code_protection
  import config_word_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Programming port (external programmer)
  input  wire logic        progVerifyMode,
  input  wire logic        extReq,
  input  wire logic        extWrite,
  input  wire logic [13:0] extAddr,
  input  wire logic [13:0] extWdata,
  output logic [13:0]      extRdata,
  output logic             extMemRead,
  output logic             extMemWrite,
  input  wire logic [13:0] memRdata,
  // Core side
  input  wire logic        coreFetch,
  output logic             coreFetchGrant,
  input  wire logic        selfWriteReq,
  input  wire logic [13:0] selfWriteAddr,
  output logic             selfWriteGrant,
  // Decoded settings
  output logic             debugDisable,
  output logic             brownoutResetEnable,
  output logic             resetPinExternal,
  output logic             resetPinPullup,
  output logic             powerupDelayEnable,
  output logic             watchdogEnable,
  output logic             codeProtected
);
  import config_word_pkg::*;

  logic [13:0] fuse_q, fuse_d;
  logic [13:0] idWord_q [ID_COUNT];
  logic [13:0] idWord_d [ID_COUNT];
  logic [13:0] extRdata_q, extRdata_d;
  logic        progSync1_q, progSync2_q;
  logic        extAllowed;
  logic        extHitCfg;
  logic        extHitId;
  logic [1:0]  extIdIdx;
  logic        guardOk;
  logic [13:0] fuseView;
  logic        apbWrite;

  // Program/verify strap from a pin: two-stage synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      progSync1_q <= 1'b0;
      progSync2_q <= 1'b0;
    end else begin
      progSync1_q <= progVerifyMode;
      progSync2_q <= progSync1_q;
    end
  end

  // Visible word with unimplemented bits forced high
  assign fuseView   = fuse_q | UNIMPL_MASK;
  assign extHitCfg  = (extAddr == CFG_WORD_ADDR);
  assign extHitId   = (extAddr[13:2] == ID_BASE_ADDR[13:2]);
  assign extIdIdx   = extAddr[1:0];
  assign extAllowed = fuse_q[POS_READ_GUARD];
  assign apbWrite   = psel & penable & pwrite;

  // Decoded settings driven from the latched word
  assign debugDisable        = fuse_q[POS_DEBUG_DIS];
  assign brownoutResetEnable = fuse_q[POS_BROWNOUT];
  assign resetPinExternal    = fuse_q[POS_RESET_PIN];
  assign resetPinPullup      = fuse_q[POS_RESET_PIN];
  assign powerupDelayEnable  = ~fuse_q[POS_PWRUP_DIS];
  assign watchdogEnable      = fuse_q[POS_WATCHDOG];
  assign codeProtected       = ~fuse_q[POS_READ_GUARD];

  // Core reads never gated by protection
  assign coreFetchGrant = coreFetch;

  write_guard u_guard (
    .guardField   (fuse_q[POS_GUARD_HI:POS_GUARD_LO]),
    .writeAddr    (selfWriteAddr),
    .writeAllowed (guardOk)
  );

  // Self-write gated by guard field and write address only
  assign selfWriteGrant = selfWriteReq & guardOk;

  // Program memory strobes for external access
  assign extMemRead  = extReq & progSync2_q & ~extWrite & ~extHitCfg & ~extHitId & extAllowed;
  assign extMemWrite = extReq & progSync2_q & extWrite & ~extHitCfg & ~extHitId & extAllowed;

  // Next state of fuse, id words and external read data
  always_comb begin
    fuse_d     = fuse_q;
    extRdata_d = extRdata_q;
    for (int i = 0; i < ID_COUNT; i++) begin
      idWord_d[i] = idWord_q[i];
    end
    if (extReq && progSync2_q) begin
      if (extHitCfg) begin
        if (extWrite) begin
          fuse_d = extWdata;
        end else begin
          extRdata_d = fuseView;
        end
      end else if (extHitId) begin
        if (extWrite) begin
          idWord_d[extIdIdx] = extWdata;
        end else begin
          extRdata_d = idWord_q[extIdIdx];
        end
      end else if (!extWrite) begin
        extRdata_d = extAllowed ? memRdata : 14'h0000;
      end
    end
  end

  // Register state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fuse_q     <= FUSE_RESET;
      extRdata_q <= 14'h0000;
      for (int i = 0; i < ID_COUNT; i++) begin
        idWord_q[i] <= ID_RESET;
      end
    end else begin
      fuse_q     <= fuse_d;
      extRdata_q <= extRdata_d;
      for (int i = 0; i < ID_COUNT; i++) begin
        idWord_q[i] <= idWord_d[i];
      end
    end
  end

  assign extRdata = extRdata_q;

  // APB: zero wait states; fuse word read-only; ids hidden from running program
  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    pready  = 1'b1;
    if (psel && penable) begin
      case (paddr)
        OFS_FUSE_WORD: begin
          prdata[13:0] = fuseView;
          pslverr      = apbWrite; // Fuse word is read-only over the bus
        end
        OFS_ACCESS_CHK: begin
          prdata[0] = guardOk;
          prdata[1] = extAllowed;
          prdata[2] = progSync2_q;
          pslverr   = apbWrite;
        end
        default: begin
          pslverr = 1'b1;
        end
      endcase
    end
  end

  // Guard field behaviour and ungated core fetch
  guard_all_a: assert property (@(posedge clock) disable iff (rst)
    (fuse_q[POS_GUARD_HI:POS_GUARD_LO] == GUARD_ALL) |-> !selfWriteGrant)
    else $error("self-write under full guard");
  guard_lower_a: assert property (@(posedge clock) disable iff (rst)
    (fuse_q[POS_GUARD_HI:POS_GUARD_LO] == GUARD_LOWER && selfWriteReq && selfWriteAddr < HALF_BOUNDARY)
    |-> !selfWriteGrant) else $error("lower half written");
  guard_none_a: assert property (@(posedge clock) disable iff (rst)
    (fuse_q[POS_GUARD_HI:POS_GUARD_LO] == GUARD_NONE && selfWriteReq) |-> selfWriteGrant)
    else $error("open memory write refused");
  guard_only_a: assert property (@(posedge clock) disable iff (rst)
    (fuse_q[POS_GUARD_HI:POS_GUARD_LO] == GUARD_NONE && selfWriteReq && !extAllowed) |-> selfWriteGrant)
    else $error("read guard blocked self-write");
  fetch_free_a: assert property (@(posedge clock) disable iff (rst)
    coreFetch |-> coreFetchGrant)
    else $error("fetch blocked");

  // External programming port behaviour
  unimpl_one_a: assert property (@(posedge clock) disable iff (rst)
    (extReq && progSync2_q && extHitCfg && !extWrite)
    |=> (extRdata[12] && extRdata[9] && extRdata[7] && extRdata[2:0] == 3'h7))
    else $error("unimplemented bit read zero");
  cfg_load_a: assert property (@(posedge clock) disable iff (rst)
    (extReq && progSync2_q && extHitCfg && extWrite) |=> (fuse_q == $past(extWdata)))
    else $error("config word not loaded");
  protect_zero_a: assert property (@(posedge clock) disable iff (rst)
    (extReq && progSync2_q && !extHitCfg && !extHitId && !extWrite && !extAllowed)
    |=> (extRdata == 14'h0000 && $stable(fuse_q)))
    else $error("protected read leaked");
  open_read_a: assert property (@(posedge clock) disable iff (rst)
    (extReq && progSync2_q && !extHitCfg && !extHitId && !extWrite && extAllowed)
    |=> (extRdata == $past(memRdata)))
    else $error("open read data wrong");
  protect_block_a: assert property (@(posedge clock) disable iff (rst)
    !extAllowed |-> !(extMemRead || extMemWrite))
    else $error("protected access strobed");
  strobe_mode_a: assert property (@(posedge clock) disable iff (rst)
    !progSync2_q |-> !(extMemRead || extMemWrite))
    else $error("memory strobed outside program mode");
  id_hidden_a: assert property (@(posedge clock) disable iff (rst)
    (!progSync2_q && extReq) |=> $stable(idWord_q[0]) && $stable(idWord_q[3]))
    else $error("id written outside program mode");

  // Decoded setting outputs
  pwrup_pol_a: assert property (@(posedge clock) disable iff (rst)
    powerupDelayEnable != fuse_q[POS_PWRUP_DIS])
    else $error("power-up polarity wrong");
  cfg_decode_a: assert property (@(posedge clock) disable iff (rst)
    (watchdogEnable == fuse_q[POS_WATCHDOG]) && (brownoutResetEnable == fuse_q[POS_BROWNOUT])
    && (resetPinPullup == resetPinExternal))
    else $error("setting decode wrong");
endmodule : config_word_code_protection

// *** dv/prog_model.sv ***
`timescale 1ns/1ps
module prog_model (
  input  wire logic        clock,
  input  wire logic        extMemRead,
  input  wire logic        extMemWrite,
  output logic             progVerifyMode,
  output logic             extReq,
  output logic             extWrite,
  output logic [13:0]      extAddr,
  output logic [13:0]      extWdata,
  output logic [13:0]      memRdata,
  output logic             strobeSeen
);
  // Flash word follows address; inverted while not read
  assign memRdata = extMemRead ? (extAddr ^ 14'h1555) : ~(extAddr ^ 14'h1555);
  // Idle pins at time zero
  initial begin
    {progVerifyMode, extReq, extWrite} = 3'h0;
    {extAddr, extWdata} = 28'h0;
    strobeSeen = 1'b0;
  end
  // Mode pin, then time for the synchroniser
  task automatic set_mode(input logic on);
    @(posedge clock);
    progVerifyMode <= on;
    repeat (3) @(posedge clock);
  endtask : set_mode
  // One request cycle, strobes sampled before the taking edge
  task automatic xfer(input logic wr, input logic [13:0] a, input logic [13:0] d);
    @(posedge clock);
    extReq <= 1'b1;
    extWrite <= wr;
    extAddr <= a;
    extWdata <= (a == 14'h2007) ? (d | 14'h2000) : d;
    #1 strobeSeen = extMemRead | extMemWrite;
    @(posedge clock);
    extReq <= 1'b0;
  endtask : xfer
endmodule : prog_model

// *** dv/config_word_code_protection_bench.sv ***
`timescale 1ns/1ps
module config_word_code_protection_bench;
  import config_word_pkg::*;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, coreFetch, coreFetchGrant;
  logic        selfWriteReq, selfWriteGrant, debugDisable, brownoutResetEnable, resetPinExternal;
  logic        resetPinPullup, powerupDelayEnable, watchdogEnable, codeProtected, strobeSeen;
  logic        progVerifyMode, extReq, extWrite, extMemRead, extMemWrite, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic [13:0] extAddr, extWdata, extRdata, memRdata, selfWriteAddr;
  int          err_total, checks_done;

  config_word_code_protection config_word_code_protection_i (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .progVerifyMode(progVerifyMode), .extReq(extReq), .extWrite(extWrite),
    .extAddr(extAddr), .extWdata(extWdata), .extRdata(extRdata), .extMemRead(extMemRead),
    .extMemWrite(extMemWrite), .memRdata(memRdata), .coreFetch(coreFetch), .coreFetchGrant(coreFetchGrant),
    .selfWriteReq(selfWriteReq), .selfWriteAddr(selfWriteAddr), .selfWriteGrant(selfWriteGrant),
    .debugDisable(debugDisable), .brownoutResetEnable(brownoutResetEnable),
    .resetPinExternal(resetPinExternal), .resetPinPullup(resetPinPullup),
    .powerupDelayEnable(powerupDelayEnable), .watchdogEnable(watchdogEnable), .codeProtected(codeProtected));
  prog_model prog_model_i (.clock(clock), .extMemRead(extMemRead), .extMemWrite(extMemWrite),
    .progVerifyMode(progVerifyMode), .extReq(extReq), .extWrite(extWrite), .extAddr(extAddr),
    .extWdata(extWdata), .memRdata(memRdata), .strobeSeen(strobeSeen));

  // Value compare, counts every check
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      $display("ERROR %s expected %h seen %h", n, x, g);
      err_total++;
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      finish_test();
    end
  endtask : apb
  // Self-write request, grant judged one cycle later
  task automatic self_wr(input logic [13:0] a, input logic x);
    @(posedge clock);
    selfWriteReq <= 1'b1;
    selfWriteAddr <= a;
    @(posedge clock);
    #1 chk("selfWriteGrant", {31'h0, x}, {31'h0, selfWriteGrant});
  endtask : self_wr

  // Erased fuse word and its decoded settings
  task automatic t_reset;
    apb(1'b0, 8'h00);
    chk("fuse", 32'h0000_3FFF, d);
    chk("wdog", 32'h1, {31'h0, watchdogEnable});
    chk("pwrup", 32'h0, {31'h0, powerupDelayEnable});
    chk("bor", 32'h1, {31'h0, brownoutResetEnable});
    chk("pin", 32'h3, {30'h0, resetPinExternal, resetPinPullup});
    self_wr(14'h0000, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  // Program guard 01 with read guard on, all settings but debug disable cleared
  task automatic t_program;
    prog_model_i.set_mode(1'b1);
    prog_model_i.xfer(1'b1, CFG_WORD_ADDR, 14'h0400);
    apb(1'b0, 8'h00);
    chk("fuse", 32'h0000_3687, d);
    chk("flags", 32'h45, {25'h0, debugDisable, brownoutResetEnable, resetPinExternal, resetPinPullup,
      powerupDelayEnable, watchdogEnable, codeProtected});
    coreFetch <= 1'b1;
    self_wr(14'h07FF, 1'b0);
    chk("fetch", 32'h1, {31'h0, coreFetchGrant});
    self_wr(14'h0800, 1'b1);
    $display("t_program done");
  endtask : t_program
  // Guarded external access, then guard 00 unprotected and guard 11 protected
  task automatic t_guard;
    prog_model_i.xfer(1'b0, CFG_WORD_ADDR, 14'h0000);
    #1 chk("cfgRd", 32'h3687, {18'h0, extRdata});
    prog_model_i.xfer(1'b0, 14'h0123, 14'h0000);
    #1 chk("rd", 32'h0, {17'h0, strobeSeen, extRdata});
    prog_model_i.xfer(1'b1, 14'h0123, 14'h0ABC);
    chk("wr", 32'h0, {31'h0, strobeSeen});
    prog_model_i.xfer(1'b1, CFG_WORD_ADDR, 14'h0040);
    self_wr(14'h0800, 1'b0);
    apb(1'b0, 8'h04);
    chk("access", 32'h6, d);
    prog_model_i.xfer(1'b0, 14'h0123, 14'h0000);
    #1 chk("rd", 32'h5476, {17'h0, strobeSeen, extRdata});
    prog_model_i.xfer(1'b1, 14'h0123, 14'h0ABC);
    chk("wrOpen", 32'h1, {31'h0, strobeSeen});
    prog_model_i.xfer(1'b1, CFG_WORD_ADDR, 14'h0C00);
    self_wr(14'h0000, 1'b1);
    $display("t_guard done");
  endtask : t_guard
  // ID words in and out of program mode, APB refusals
  task automatic t_ids;
    prog_model_i.xfer(1'b1, 14'h2003, 14'h0ABC);
    prog_model_i.set_mode(1'b0);
    prog_model_i.xfer(1'b1, 14'h2003, 14'h0111);
    apb(1'b0, 8'h10);
    chk("idApb", 32'h1, {31'h0, e});
    apb(1'b1, 8'h00);
    chk("wrFuse", 32'h1, {31'h0, e});
    prog_model_i.set_mode(1'b1);
    prog_model_i.xfer(1'b0, 14'h2003, 14'h0000);
    #1 chk("id", 32'h0ABC, {18'h0, extRdata});
    $display("t_ids done");
  endtask : t_ids

  // Clock and main sequence
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    {err_total, checks_done} = 0;
    {rst, psel, penable, pwrite, coreFetch, selfWriteReq} = 6'h21;
    {paddr, pwdata, selfWriteAddr} = 54'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_program();
    t_guard();
    t_ids();
    finish_test();
  end
endmodule : config_word_code_protection_bench
